// *** src/dpm_map.vh ***
// constants for the dual-port mailbox host controller
// assumes one 200 MHz clock and a 13-bit word-addressed memory
`ifndef DPM_MAP_VH
`define DPM_MAP_VH
`define DPM_ADDR_W 13
`define DPM_DATA_W 16
`define DPM_MAIL_LEFT 13'h1ffe
`define DPM_MAIL_RIGHT 13'h1fff
// own register map (word index on the command port)
`define DPM_REG_CTRL 4'h0
`define DPM_REG_ADDR 4'h1
`define DPM_REG_WDATA 4'h2
`define DPM_REG_RDATA 4'h3
`define DPM_REG_STATUS 4'h4
// ctrl bits: 0 go, 1 write, 2 semaphore space, 3 block writes (slave mode), 4 init flags
`define DPM_CTRL_GO 0
`define DPM_CTRL_WRITE 1
`define DPM_CTRL_SEM 2
`define DPM_CTRL_BLOCK 3
`define DPM_CTRL_INIT 4
// access strobe width: at least 70 ns
`define DPM_ACCESS_NS 70
`define DPM_CLK_MHZ 200
`define DPM_ACCESS_CYC ((`DPM_ACCESS_NS * `DPM_CLK_MHZ + 999) / 1000)
`endif

// *** src/dpm_host.v ***
// host-side controller for one port of a dual-port mailbox memory
// assumes the memory pins are asynchronous; inputs are synchronised here
//
// Behaviour
// - unused interrupts leave top words plain
// - hosts initialise both flags after power-up; this controller clears only its own, with one read of its own mailbox
// - system holds slave busy high or low
// - depth-stacked busy outputs are ANDed
// - active-low tokens, verify by reading back
// - deassert select between semaphore polls
`timescale 1ns/1ps
`include "dpm_map.vh"

module dpm_host
(
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // command port
  input wire [3:0] cmdAddr,
  input wire [31:0] cmdWdata,
  input wire cmdWr,
  input wire cmdRd,
  output reg [31:0] cmdRdata,
  // memory port pins
  output reg chipSel_n,
  output reg token_space_select_n,
  output reg outEn_n,
  output reg readWrite_n,
  output reg [`DPM_ADDR_W-1:0] memAddr,
  input wire [`DPM_DATA_W-1:0] memDataIn,
  output reg [`DPM_DATA_W-1:0] memDataOut,
  output reg memDataOe_n,
  input wire mail_flag_n,
  input wire collisionIn_n,
  output reg collisionOut,
  output reg collisionOe_n,
  // this controller's side: 0 left, 1 right
  input wire sideRight
);

localparam ST_IDLE = 2'h0;
localparam ST_SETUP = 2'h1;
localparam ST_STROBE = 2'h2;
localparam ST_END = 2'h3;
localparam integer ACC_INT = `DPM_ACCESS_CYC;
// strobe count fits eight bits at any sane clock
localparam [7:0] ACC_CYC = ACC_INT[7:0];

reg [1:0] state;
reg [7:0] count;
reg [4:0] ctrl;
reg [`DPM_ADDR_W-1:0] addrReg;
reg [`DPM_DATA_W-1:0] wdataReg;
reg [`DPM_DATA_W-1:0] rdataReg;
reg [1:0] initStep;
reg lostToken;
reg sawBusy;
reg flagSync1;
reg flagSync;
reg busySync1;
reg busySync;
reg [`DPM_DATA_W-1:0] dataSync1;
reg [`DPM_DATA_W-1:0] dataSync;

////////////////////////////////////////////////////////////////////////
// command port decode

// one decode for every register write strobe
function regHit;
  input strobe;
  input [3:0] index;
  input [3:0] target;
  begin
    regHit = strobe && index == target;
  end
endfunction

wire ctrlWrite;
wire addrWrite;
wire wdataWrite;
assign ctrlWrite = regHit(cmdWr, cmdAddr, `DPM_REG_CTRL);
assign addrWrite = regHit(cmdWr, cmdAddr, `DPM_REG_ADDR);
assign wdataWrite = regHit(cmdWr, cmdAddr, `DPM_REG_WDATA);

wire [`DPM_ADDR_W-1:0] ownMail;
wire [`DPM_ADDR_W-1:0] farMail;
// side strap is only read as a level; it must not move in operation
assign ownMail = sideRight ? `DPM_MAIL_RIGHT : `DPM_MAIL_LEFT;
assign farMail = sideRight ? `DPM_MAIL_LEFT : `DPM_MAIL_RIGHT;

////////////////////////////////////////////////////////////////////////
// synchronisers; pins are not on mclk

always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    flagSync1 <= 1'b1;
    flagSync <= 1'b1;
    busySync1 <= 1'b1;
    busySync <= 1'b1;
    dataSync1 <= 16'h0000;
    dataSync <= 16'h0000;
  end
  else
  begin
    flagSync1 <= mail_flag_n;
    flagSync <= flagSync1;
    // a depth-stacked array hands in its busy lines already ANDed
    busySync1 <= collisionIn_n;
    busySync <= busySync1;
    dataSync1 <= memDataIn;
    dataSync <= dataSync1;
  end
end

////////////////////////////////////////////////////////////////////////
// command registers

always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    cmdRdata <= 32'h00000000;
    addrReg <= {`DPM_ADDR_W{1'b0}};
    wdataReg <= 16'h0000;
  end
  else
  begin
    cmdRdata <= 32'h00000000;
    if (addrWrite)
      addrReg <= cmdWdata[`DPM_ADDR_W-1:0];
    if (wdataWrite)
      wdataReg <= cmdWdata[`DPM_DATA_W-1:0];
    if (cmdRd)
    begin
      case (cmdAddr)
        `DPM_REG_CTRL: cmdRdata <= {27'h0000000, ctrl};
        `DPM_REG_ADDR: cmdRdata <= {19'h00000, addrReg};
        `DPM_REG_WDATA: cmdRdata <= {16'h0000, wdataReg};
        `DPM_REG_RDATA: cmdRdata <= {16'h0000, rdataReg};
        `DPM_REG_STATUS:
          cmdRdata <= {27'h0000000, lostToken, sawBusy, busySync, flagSync,
            state != ST_IDLE || initStep != 2'h0};
        default: cmdRdata <= 32'h00000000;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////
// access sequencer; holds each access for the slowest memory strobe

always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    state <= ST_IDLE;
    count <= 8'h00;
    ctrl <= 5'h00;
    initStep <= 2'h0;
    rdataReg <= 16'h0000;
    lostToken <= 1'b0;
    sawBusy <= 1'b0;
    chipSel_n <= 1'b1;
    token_space_select_n <= 1'b1;
    outEn_n <= 1'b1;
    readWrite_n <= 1'b1;
    memAddr <= {`DPM_ADDR_W{1'b0}};
    memDataOut <= 16'h0000;
    memDataOe_n <= 1'b1;
    collisionOut <= 1'b1;
    collisionOe_n <= 1'b1;
  end
  else
  begin
    // slave mode: drive busy high for free writes, low to block them
    collisionOut <= ~ctrl[`DPM_CTRL_BLOCK];
    collisionOe_n <= 1'b0;
    if (ctrlWrite)
      ctrl[`DPM_CTRL_BLOCK] <= cmdWdata[`DPM_CTRL_BLOCK];
    case (state)
      ST_IDLE:
      begin
        if (initStep != 2'h0)
        begin
          // clear own flag with a single read of own mailbox
          memAddr <= ownMail;
          readWrite_n <= 1'b1;
          token_space_select_n <= 1'b1;
          ctrl[`DPM_CTRL_SEM] <= 1'b0;
          ctrl[`DPM_CTRL_WRITE] <= 1'b0;
          initStep <= initStep - 2'h1;
          state <= ST_SETUP;
        end
        else if (ctrlWrite)
        begin
          ctrl <= cmdWdata[4:0];
          if (cmdWdata[`DPM_CTRL_INIT])
            initStep <= 2'h1;
          else if (cmdWdata[`DPM_CTRL_GO])
          begin
            // semaphore space only decodes three low bits
            memAddr <= cmdWdata[`DPM_CTRL_SEM] ? {10'h000, addrReg[2:0]} : addrReg;
            readWrite_n <= ~cmdWdata[`DPM_CTRL_WRITE];
            memDataOut <= cmdWdata[`DPM_CTRL_SEM] ? {15'h0000, wdataReg[0]} : wdataReg;
            sawBusy <= 1'b0;
            state <= ST_SETUP;
          end
        end
      end
      ST_SETUP:
      begin
        // select asserted a cycle after address; busy decides on select and address
        if (ctrl[`DPM_CTRL_SEM])
          token_space_select_n <= 1'b0;
        else
          chipSel_n <= 1'b0;
        outEn_n <= ~readWrite_n ? 1'b1 : 1'b0;
        memDataOe_n <= readWrite_n;
        count <= ACC_CYC;
        state <= ST_STROBE;
      end
      ST_STROBE:
      begin
        if (!busySync)
          sawBusy <= 1'b1;
        if (count == 8'h00)
        begin
          rdataReg <= dataSync;
          // ownership check: a zero back means we hold the token
          if (ctrl[`DPM_CTRL_SEM] && readWrite_n)
            lostToken <= dataSync[0];
          state <= ST_END;
        end
        else
          count <= count - 8'h01;
      end
      ST_END:
      begin
        // drop selects so the next semaphore poll relatches
        chipSel_n <= 1'b1;
        token_space_select_n <= 1'b1;
        outEn_n <= 1'b1;
        readWrite_n <= 1'b1;
        memDataOe_n <= 1'b1;
        ctrl[`DPM_CTRL_GO] <= 1'b0;
        state <= ST_IDLE;
      end
      default: state <= ST_IDLE;
    endcase
  end
end

endmodule

// *** test/dpm_host_asserts.sv ***
// assertions on the host controller's memory pins
// bound into dpm_host, sees its ports only
`timescale 1ns/1ps
module dpm_host_asserts
(
  input wire mclk,
  input wire rst_n,
  input wire chipSel_n,
  input wire token_space_select_n,
  input wire outEn_n,
  input wire readWrite_n,
  input wire [12:0] memAddr,
  input wire [15:0] memDataOut,
  input wire memDataOe_n,
  input wire collisionOe_n
);
  wire semN = token_space_select_n;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sem_rel_a: assert property (!semN |-> ##[1:30] semN) else $error("select stuck");
  sem_wr_a: assert property (!semN && !readWrite_n |-> !memDataOe_n) else $error("no drive");
  one_space_a: assert property (chipSel_n || semN) else $error("two spaces");
  busy_pin_a: assert property (!collisionOe_n |=> !collisionOe_n) else $error("busy float");
  sem_rd_a: assert property ($fell(semN) && readWrite_n |-> !outEn_n) else $error("no oe");
  addr_hold_a: assert property (!chipSel_n && !$past(chipSel_n) |-> $stable(memAddr))
    else $error("address moved");
  data_hold_a: assert property (!chipSel_n && !readWrite_n |-> $stable(memDataOut))
    else $error("data moved");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind dpm_host dpm_host_asserts chk_u (.mclk(mclk), .rst_n(rst_n), .chipSel_n(chipSel_n),
  .token_space_select_n(token_space_select_n), .outEn_n(outEn_n), .readWrite_n(readWrite_n),
  .memAddr(memAddr), .memDataOut(memDataOut), .memDataOe_n(memDataOe_n),
  .collisionOe_n(collisionOe_n));

// *** test/dpm_dev_model.sv ***
// behavioural dual-port memory, host on the left port
// far port is worked by the bench through tasks and variables
`timescale 1ns/1ps
module dpm_dev_model
(
  input wire cs_n,
  input wire sem_n,
  input wire oe_n,
  input wire rw_n,
  input wire [12:0] a,
  input wire [15:0] d,
  output wire [15:0] q,
  output reg flag_n = 1'b0,
  output reg busy_n
);
  // flags power up low on purpose: the host has to clear flag_n, the far side farFlag_n
  reg [15:0] mem [0:8191];
  reg [15:0] hold;
  reg [15:0] semQ;
  reg [15:0] owner = 16'h0;
  reg [15:0] pend = 16'h0;
  reg farFlag_n = 1'b0;
  reg farOn = 1'b0;
  reg [12:0] farA;
  reg open = 1'b1;
  // who: 1 host, 2 far side
  task semWr(input [1:0] who, input [2:0] s, input b);
    if (!b && owner[2*s+:2] == 2'h0) owner[2*s+:2] = who;
    else if (!b && owner[2*s+:2] != who) pend[2*s+:2] = who;
    else if (b && owner[2*s+:2] == who)
    begin
      owner[2*s+:2] = pend[2*s+:2];
      pend[2*s+:2] = 2'h0;
    end
  endtask
  task farWr(input [12:0] fa, input [15:0] fd);
    mem[fa] = fd;
    if (fa == 13'h1ffe) flag_n = 1'b0;
  endtask
  task farRd(input [12:0] fa);
    if (fa == 13'h1fff) farFlag_n = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    // far side always wins here, so only one busy can ever be low
    busy_n = !(farOn && !cs_n && a == farA);
    if (!cs_n && !rw_n && busy_n) mem[a] = d;
    if (!cs_n && !rw_n && busy_n && a == 13'h1fff) farFlag_n = 1'b0;
    if (!cs_n && !oe_n && busy_n && a == 13'h1ffe) flag_n = 1'b1;
    if (!sem_n && !rw_n) semWr(2'h1, a[2:0], d[0]);
    if (sem_n || oe_n) open = 1'b1;
    else if (open)
    begin
      semQ = {16{owner[2*a[2:0]+:2] != 2'h1}};
      open = 1'b0;
    end
    if (!oe_n && (!cs_n || !sem_n)) hold = !cs_n ? mem[a] : semQ;
  end
  // released bus shows the inverse, never a stale copy
  assign q = (!oe_n && (!cs_n || !sem_n)) ? hold : ~hold;
endmodule

// *** test/dpm_host_test.sv ***
// self-checking bench: host controller against the device model
// assumes the model as far side; far port worked by hierarchy
`timescale 1ns/1ps
module dpm_host_test;
  reg mclk, rst_n, cmdWr, cmdRd;
  reg [3:0] cmdAddr;
  reg [31:0] cmdWdata, rv;
  wire [31:0] cmdRdata;
  wire cs_n, sem_n, oe_n, rw_n, doe_n, flag_n, busy_n, bOut, bOe;
  wire [12:0] addr;
  wire [15:0] dout, devQ;
  wire [15:0] dbus = doe_n ? devQ : dout;
  integer fails = 0, checked = 0, n;
  dpm_host dut_u (.mclk(mclk), .rst_n(rst_n), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
    .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata), .chipSel_n(cs_n),
    .token_space_select_n(sem_n), .outEn_n(oe_n), .readWrite_n(rw_n), .memAddr(addr),
    .memDataIn(dbus), .memDataOut(dout), .memDataOe_n(doe_n), .mail_flag_n(flag_n),
    .collisionIn_n(busy_n), .collisionOut(bOut), .collisionOe_n(bOe), .sideRight(1'b0));
  dpm_dev_model dev (.cs_n(cs_n), .sem_n(sem_n), .oe_n(oe_n), .rw_n(rw_n), .a(addr),
    .d(dbus), .q(devQ), .flag_n(flag_n), .busy_n(busy_n));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [15:0] e, input [15:0] g, input string nm);
  begin
    checked = checked + 1;
    if (e !== g)
    begin
      fails = fails + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task wr(input [3:0] ad, input [31:0] d);
  begin
    @(posedge mclk);
    cmdAddr <= ad;
    cmdWdata <= d;
    cmdWr <= 1'b1;
    @(posedge mclk);
    cmdWr <= 1'b0;
  end
  endtask
  task rd(input [3:0] ad);
  begin
    @(posedge mclk);
    cmdAddr <= ad;
    cmdRd <= 1'b1;
    @(posedge mclk);
    cmdRd <= 1'b0;
    #1 rv = cmdRdata;
  end
  endtask
  // start an access, poll until idle, leave read data in rv
  task acc(input [12:0] ad, input [15:0] d, input [4:0] c);
  begin
    wr(4'h1, {19'h0, ad});
    wr(4'h2, {16'h0, d});
    wr(4'h0, {27'h0, c});
    n = 0;
    rd(4'h4);
    while (rv[0] && n < 99)
    begin
      rd(4'h4);
      n = n + 1;
    end
    if (rv[0]) chk(16'h0, rv[15:0] & 16'h1, "access idle");
    rd(4'h3);
  end
  endtask
  task report_and_stop;
  begin
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  initial
  begin
    #30000;
    fails = fails + 1;
    report_and_stop;
  end
  initial
  begin
    {rst_n, cmdWr, cmdRd, cmdAddr, cmdWdata} = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    acc(13'h0, 16'h0, 5'h11);
    rd(4'h4);
    chk(16'h2, rv[15:0] & 16'h2, "init flag");
    dev.farWr(13'h1ffe, 16'hbeef);
    rd(4'h4);
    rd(4'h4);
    chk(16'h0, rv[15:0] & 16'h2, "mail in");
    acc(13'h1ffe, 16'h0, 5'h1);
    chk(16'hbeef, rv[15:0], "mail word");
    rd(4'h4);
    chk(16'h2, rv[15:0] & 16'h2, "mail clear");
    acc(13'h1fff, 16'ha5c3, 5'h3);
    chk(16'h0, {15'h0, dev.farFlag_n}, "mail out");
    dev.farRd(13'h1fff);
    chk(16'h1, {15'h0, dev.farFlag_n}, "far clear");
    chk(16'ha5c3, dev.mem[13'h1fff], "top word");
    $display("mailbox test done");
    acc(13'h1ff5, 16'hfffe, 5'h7);
    acc(13'h0005, 16'h0, 5'h5);
    chk(16'h0, rv[15:0], "token taken");
    dev.semWr(2'h2, 3'h5, 1'b0);
    acc(13'h0005, 16'h0, 5'h5);
    chk(16'h0, rv[15:0], "token held");
    acc(13'h0005, 16'h1, 5'h7);
    acc(13'h0005, 16'h0, 5'h5);
    chk(16'hffff, rv[15:0], "token passed");
    rd(4'h4);
    chk(16'h10, rv[15:0] & 16'h10, "lost token");
    $display("semaphore test done");
    dev.mem[13'h0a0] = 16'h0;
    dev.farA = 13'h0a0;
    dev.farOn = 1'b1;
    acc(13'h0a0, 16'h1234, 5'h3);
    dev.farOn = 1'b0;
    chk(16'h0, dev.mem[13'h0a0], "inhibit");
    rd(4'h4);
    chk(16'h8, rv[15:0] & 16'h8, "busy seen");
    acc(13'h0a0, 16'h1234, 5'h3);
    chk(16'h1234, dev.mem[13'h0a0], "plain write");
    wr(4'h0, 32'h8);
    rd(4'h0);
    chk(16'h8, rv[15:0], "ctrl word");
    chk(16'h0, {14'h0, bOe, bOut}, "busy drive");
    $display("busy test done");
    report_and_stop;
  end
endmodule
